// ### rtl/ooc_onoff_ctrl.sv
// On/off state controller with power sequencer and register port
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module ooc_onoff_ctrl
  import ooc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [1:0] charger_input_detail_i,
  input wire logic enable_input_n_i,
  input wire logic supply_ok_i,
  input wire logic overtemp_i,
  input wire logic sys_uv_i,
  input wire logic sys_ov_i,
  input wire logic wdt_expired_i,
  input wire logic manual_reset_flag_i,
  output logic [3:0] rail_en_o,
  output logic [6:0] state_o,
  output logic wake_flag_o
);
  ooc_state_t state;
  ooc_state_t next_state;
  logic [1:0] software_power_request;
  logic main_bias_request;
  logic [3:0] monitor_selector;
  logic [15:0] force_cfg;
  logic [7:0] slot_map;
  logic [15:0] up_dly;
  logic [15:0] dn_dly;
  logic wake_flag;
  logic pu_done;
  logic enable_q;
  logic chg_valid_q;
  logic [3:0] seq_on;
  logic seq_busy;
  logic seq_done;
  logic chg_valid, chg_rise, enable_fall, lockout, kill, kill_cold;
  logic t4, t6, t7a, all_forced_off;
  logic start_up, start_down;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input conditions
  assign chg_valid = (charger_input_detail_i == OOC_CHG_VALID);
  assign chg_rise = chg_valid && !chg_valid_q;
  assign enable_fall = !enable_input_n_i && enable_q;
  assign lockout = overtemp_i || sys_uv_i || sys_ov_i;
  assign kill = (software_power_request != OOC_REQ_NONE) || wdt_expired_i
    || manual_reset_flag_i;
  assign kill_cold = (software_power_request == OOC_REQ_COLD);
  assign all_forced_off = &force_cfg[OOC_FORCE_OFF_LSB +: OOC_NUM_RES];
  assign t6 = (monitor_selector != OOC_MUX_IDLE) || chg_valid
    || (|force_cfg[OOC_FORCE_ON_LSB +: OOC_NUM_RES]) || wake_flag;
  assign t4 = main_bias_request || t6;
  assign t7a = !pu_done && !all_forced_off && wake_flag
    && (|force_cfg[OOC_FORCE_SEQ_LSB +: OOC_NUM_RES]);

  // Edge memories for enable and charger
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_q <= 1'b1;
      chg_valid_q <= 1'b0;
    end else begin
      enable_q <= enable_input_n_i;
      chg_valid_q <= chg_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: supply loss, then lockout, then kill, then wake
  always_comb begin
    next_state = state;
    start_up = 1'b0;
    start_down = 1'b0;
    if (!supply_ok_i) begin
      next_state = OOC_ST_REMOVED;
    end else begin
      case (state)
        OOC_ST_REMOVED: begin
          next_state = OOC_ST_SHUTDOWN;
        end
        OOC_ST_SHIP: begin
          if (chg_rise || enable_fall) begin
            next_state = OOC_ST_SHUTDOWN;
          end
        end
        OOC_ST_SHUTDOWN: begin
          if (lockout) begin
            next_state = OOC_ST_SHUTDOWN;
          end else if (software_power_request == OOC_REQ_SHIP && enable_input_n_i) begin
            next_state = OOC_ST_SHIP;
          end else if (!kill && t4) begin
            next_state = OOC_ST_STANDBY;
          end
        end
        OOC_ST_STANDBY: begin
          if (lockout) begin
            next_state = OOC_ST_SHUTDOWN;
          end else if (!t4 || kill) begin
            next_state = OOC_ST_SHUTDOWN;
          end else if (t6 && t7a) begin
            next_state = OOC_ST_PWRUP;
            start_up = 1'b1;
          end else if (t6) begin
            next_state = OOC_ST_ON;
          end
        end
        OOC_ST_PWRUP: begin
          if (lockout) begin
            next_state = OOC_ST_SHUTDOWN;
          end else if (seq_done) begin
            next_state = OOC_ST_ON;
          end
        end
        OOC_ST_ON: begin
          if (lockout) begin
            next_state = OOC_ST_SHUTDOWN;
          end else if (pu_done && (kill || all_forced_off)) begin
            next_state = OOC_ST_PWRDN;
            start_down = 1'b1;
          end else if (!t6 || kill) begin
            next_state = OOC_ST_STANDBY;
          end
        end
        OOC_ST_PWRDN: begin
          if (lockout) begin
            next_state = OOC_ST_SHUTDOWN;
          end else if (seq_done) begin
            next_state = OOC_ST_STANDBY;
          end
        end
        default: begin
          next_state = OOC_ST_SHUTDOWN;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= OOC_ST_REMOVED;
    end else begin
      state <= next_state;
    end
  end

  // Power-up-done memory, cleared when power goes down
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pu_done <= 1'b0;
    end else if (state == OOC_ST_PWRUP && next_state == OOC_ST_ON) begin
      pu_done <= 1'b1;
    end else if (next_state == OOC_ST_STANDBY || next_state == OOC_ST_SHUTDOWN
                 || next_state == OOC_ST_REMOVED) begin
      pu_done <= 1'b0;
    end
  end

  // Wake flags survive reset-caused shutdown except from on, where a kill clears them; a set beats a clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_flag <= 1'b0;
    end else if (enable_fall || chg_rise || kill_cold) begin
      wake_flag <= 1'b1;
    end else if ((kill && state == OOC_ST_ON) || next_state == OOC_ST_SHIP) begin
      wake_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master sequencing timer
  ooc_seq_timer u_seq (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .start_up_i(start_up),
    .start_down_i(start_down),
    .slot_map_i(slot_map),
    .up_dly_i(up_dly),
    .dn_dly_i(dn_dly),
    .seq_on_o(seq_on),
    .busy_o(seq_busy),
    .done_o(seq_done)
  );

  // Rail enables: force-off wins, then force-on, sequencer or software.
  // Sequencer outputs count only inside a run or after a completed power-up, so a run cut by lockout
  // cannot leave rails on when standby is entered later on bias alone.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rail_en_o <= 4'h0;
    end else if (state == OOC_ST_SHUTDOWN || state == OOC_ST_SHIP
                 || state == OOC_ST_REMOVED) begin
      rail_en_o <= 4'h0;
    end else begin
      rail_en_o <= ~force_cfg[OOC_FORCE_OFF_LSB +: 4] & (force_cfg[OOC_FORCE_ON_LSB +: 4]
        | (force_cfg[OOC_FORCE_SEQ_LSB +: 4] & seq_on
           & {4{pu_done || state == OOC_ST_PWRUP || state == OOC_ST_PWRDN}})
        | force_cfg[OOC_FORCE_SW_LSB +: 4]);
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_o <= 7'h01;
      wake_flag_o <= 1'b0;
    end else begin
      state_o <= next_state;
      wake_flag_o <= wake_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; request code drops once the device is down
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      software_power_request <= OOC_REQ_NONE;
      main_bias_request <= 1'b0;
      monitor_selector <= OOC_MUX_IDLE;
    end else if (wr_i && hit(addr_i, OOC_ADDR_CTRL)) begin
      software_power_request <= wdata_i[OOC_CTRL_REQ_LSB +: 2];
      main_bias_request <= wdata_i[OOC_CTRL_BIAS_BIT];
      monitor_selector <= wdata_i[OOC_CTRL_MUX_LSB +: 4];
    end else if (state == OOC_ST_SHUTDOWN && software_power_request != OOC_REQ_SHIP
                 || state == OOC_ST_SHIP || state == OOC_ST_REMOVED) begin
      software_power_request <= OOC_REQ_NONE;
    end
  end

  // Resource and slot configuration
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      force_cfg <= OOC_FORCE_RST;
      slot_map <= OOC_SLOT_RST;
      up_dly <= OOC_DLY_RST;
      dn_dly <= OOC_DLY_RST;
    end else if (wr_i) begin
      if (hit(addr_i, OOC_ADDR_FORCE)) begin
        force_cfg <= wdata_i[15:0];
      end
      if (hit(addr_i, OOC_ADDR_SLOT)) begin
        slot_map <= wdata_i[7:0];
      end
      if (hit(addr_i, OOC_ADDR_UP_DLY)) begin
        up_dly <= wdata_i[15:0];
      end
      if (hit(addr_i, OOC_ADDR_DN_DLY)) begin
        dn_dly <= wdata_i[15:0];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (!rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (hit(addr_i, OOC_ADDR_CTRL)) begin
      rdata_o <= {25'h0, monitor_selector, main_bias_request, software_power_request};
    end else if (hit(addr_i, OOC_ADDR_FORCE)) begin
      rdata_o <= {16'h0, force_cfg};
    end else if (hit(addr_i, OOC_ADDR_SLOT)) begin
      rdata_o <= {24'h0, slot_map};
    end else if (hit(addr_i, OOC_ADDR_UP_DLY)) begin
      rdata_o <= {16'h0, up_dly};
    end else if (hit(addr_i, OOC_ADDR_DN_DLY)) begin
      rdata_o <= {16'h0, dn_dly};
    end else if (hit(addr_i, OOC_ADDR_STATUS)) begin
      rdata_o <= {18'h0, seq_busy, rail_en_o, pu_done, wake_flag, state};
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_pwrdn_start;
    state == OOC_ST_ON && next_state == OOC_ST_PWRDN;
  endsequence
  sequence s_in_pwrdn;
    state == OOC_ST_PWRDN;
  endsequence

  a_lockout_shutdown: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    supply_ok_i && lockout && !(state inside {OOC_ST_REMOVED, OOC_ST_SHIP})
    |=> state == OOC_ST_SHUTDOWN) else $error("lockout did not force shutdown");
  a_supply_wake: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state == OOC_ST_REMOVED && supply_ok_i |=> state == OOC_ST_SHUTDOWN)
    else $error("supply return did not wake");
  a_ship_enter: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $changed(state) && state == OOC_ST_SHIP |-> $past(enable_input_n_i))
    else $error("ship entered with enable asserted");
  a_ship_exit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state == OOC_ST_SHIP && supply_ok_i && (chg_rise || enable_fall)
    |=> state == OOC_ST_SHUTDOWN) else $error("ship did not exit on wake");
  a_standby_drop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state == OOC_ST_STANDBY && supply_ok_i && !lockout && kill
    |=> state == OOC_ST_SHUTDOWN) else $error("standby ignored kill");
  a_wake_set: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    enable_fall || chg_rise || kill_cold |=> wake_flag ##1 wake_flag_o)
    else $error("wake flag not set");
  a_pwrdn_seq: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    s_pwrdn_start |=> s_in_pwrdn ##0 seq_busy) else $error("power-down not launched");
  a_pwrup_done: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state == OOC_ST_PWRUP && seq_done && supply_ok_i && !lockout
    |=> state == OOC_ST_ON ##1 pu_done) else $error("power-up done ignored");
  a_rail_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state == OOC_ST_SHUTDOWN [*2] |-> rail_en_o == 4'h0)
    else $error("rail on in shutdown");
endmodule // ooc_onoff_ctrl

// ### include/ooc_pkg.sv
// Package holding constants and types of the on/off state controller
package ooc_pkg;
  // Register byte addresses
  localparam logic [7:0] OOC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OOC_ADDR_FORCE = 8'h04;
  localparam logic [7:0] OOC_ADDR_SLOT = 8'h08;
  localparam logic [7:0] OOC_ADDR_UP_DLY = 8'h0C;
  localparam logic [7:0] OOC_ADDR_DN_DLY = 8'h10;
  localparam logic [7:0] OOC_ADDR_STATUS = 8'h14;
  // Control register field positions
  localparam int OOC_CTRL_REQ_LSB = 0;
  localparam int OOC_CTRL_BIAS_BIT = 2;
  localparam int OOC_CTRL_MUX_LSB = 3;
  // Force register field positions
  localparam int OOC_FORCE_ON_LSB = 0;
  localparam int OOC_FORCE_OFF_LSB = 4;
  localparam int OOC_FORCE_SEQ_LSB = 8;
  localparam int OOC_FORCE_SW_LSB = 12;
  // Software request codes
  localparam logic [1:0] OOC_REQ_NONE = 2'h0;
  localparam logic [1:0] OOC_REQ_COLD = 2'h1;
  localparam logic [1:0] OOC_REQ_OFF = 2'h2;
  localparam logic [1:0] OOC_REQ_SHIP = 2'h3;
  // Charger detail code meaning valid and debounced
  localparam logic [1:0] OOC_CHG_VALID = 2'h3;
  localparam logic [3:0] OOC_MUX_IDLE = 4'h0;
  // Reset values
  localparam logic [15:0] OOC_FORCE_RST = 16'h0F00;
  localparam logic [7:0] OOC_SLOT_RST = 8'hE4;
  localparam logic [15:0] OOC_DLY_RST = 16'h1111;
  // Sequencer tick: slot delays count in ticks of this length
  localparam int OOC_CLK_PERIOD_NS = 5;
  localparam int OOC_SEQ_TICK_NS = 1000;
  localparam int OOC_SEQ_TICK_CYCLES = OOC_SEQ_TICK_NS / OOC_CLK_PERIOD_NS;
  localparam int OOC_NUM_RES = 4;
  // Controller states, one-hot
  typedef enum logic [6:0] {
    OOC_ST_REMOVED = 7'h01,
    OOC_ST_SHIP = 7'h02,
    OOC_ST_SHUTDOWN = 7'h04,
    OOC_ST_STANDBY = 7'h08,
    OOC_ST_PWRUP = 7'h10,
    OOC_ST_ON = 7'h20,
    OOC_ST_PWRDN = 7'h40
  } ooc_state_t;
endpackage

// ### rtl/ooc_seq_timer.sv
// Master sequencing timer producing four ordered slot events
`timescale 1ns/10ps
module ooc_seq_timer
  import ooc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic start_up_i,
  input wire logic start_down_i,
  input wire logic [7:0] slot_map_i,
  input wire logic [15:0] up_dly_i,
  input wire logic [15:0] dn_dly_i,
  output logic [3:0] seq_on_o,
  output logic busy_o,
  output logic done_o
);
  logic dir_up;
  logic [1:0] slot;
  logic [3:0] dly_cnt;
  logic [7:0] tick_cnt;
  logic tick;
  logic slot_fire;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler giving one tick per sequencer time unit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt <= 8'h00;
    end else if (!busy_o || tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
  assign tick = (tick_cnt == 8'(OOC_SEQ_TICK_CYCLES - 1));
  assign slot_fire = busy_o && tick && (dly_cnt == 4'h0);

  // Slot walk: up runs slots 0..3, down runs 3..0
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      dir_up <= 1'b1;
      slot <= 2'h0;
      dly_cnt <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o && (start_up_i || start_down_i)) begin
        busy_o <= 1'b1;
        dir_up <= start_up_i;
        slot <= start_up_i ? 2'h0 : 2'h3;
        dly_cnt <= start_up_i ? up_dly_i[3:0] : dn_dly_i[15:12];
      end else if (slot_fire) begin
        if ((dir_up && slot == 2'h3) || (!dir_up && slot == 2'h0)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          slot <= dir_up ? slot + 2'h1 : slot - 2'h1;
          dly_cnt <= dir_up ? up_dly_i[4*(slot+2'h1) +: 4] : dn_dly_i[4*(slot-2'h1) +: 4];
        end
      end else if (busy_o && tick) begin
        dly_cnt <= dly_cnt - 4'h1;
      end
    end
  end

  // Each resource follows the event of its slot
  generate
    for (genvar r = 0; r < OOC_NUM_RES; r++) begin : g_res
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          seq_on_o[r] <= 1'b0;
        end else if (slot_fire && slot_map_i[2*r +: 2] == slot) begin
          seq_on_o[r] <= dir_up;
        end
      end
    end
  endgenerate
endmodule // ooc_seq_timer

// ### testbench/ooc_button_model.sv
// Pushbutton and charger source facing the controller pins
`timescale 1ns/10ps
module ooc_button_model
  import ooc_pkg::*;
(
  input wire logic press_i,
  input wire logic plug_i,
  output logic enable_input_n_o,
  output logic [1:0] charger_input_detail_o
);
  // Levels arrive already debounced; button pulls the pin low
  assign enable_input_n_o = ~press_i;
  assign charger_input_detail_o = plug_i ? OOC_CHG_VALID : 2'h0;
endmodule // ooc_button_model

// ### testbench/on_off_state_controller_tb.sv
// Self-checking bench for the on/off state controller
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module on_off_state_controller_tb;
  import ooc_pkg::*;
  logic sys_clk_i = 0;
  logic nrst_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic [31:0] rdata_o;
  logic [1:0] chg;
  logic en_n;
  logic press = 0;
  logic plug = 0;
  logic supply_ok_i = 1;
  logic [2:0] lock = 3'h0;
  logic wdt_expired_i = 0;
  logic manual_reset_flag_i = 0;
  logic [3:0] rail_en_o;
  logic [6:0] state_o;
  logic wake_flag_o;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] d;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #2.5 sys_clk_i = ~sys_clk_i;
  ooc_button_model u_ooc_button_model (.press_i(press), .plug_i(plug),
    .enable_input_n_o(en_n), .charger_input_detail_o(chg));
  ooc_onoff_ctrl u_ooc_onoff_ctrl (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .charger_input_detail_i(chg), .enable_input_n_i(en_n), .supply_ok_i(supply_ok_i),
    .overtemp_i(lock[0]), .sys_uv_i(lock[1]), .sys_ov_i(lock[2]),
    .wdt_expired_i(wdt_expired_i), .manual_reset_flag_i(manual_reset_flag_i),
    .rail_en_o(rail_en_o), .state_o(state_o), .wake_flag_o(wake_flag_o));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task print_verdict();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus tasks; only defined request codes are written
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask
  // Poll the state under a cycle bound, then compare
  task ws(input ooc_state_t s, input int n);
    int i;
    i = 0;
    while (state_o !== s && i < n) begin
      @(posedge sys_clk_i);
      #1;
      i++;
    end
    `CHK(state_o, s)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(state_o, OOC_ST_REMOVED)
    nrst_i <= 1'b1;
    ws(OOC_ST_SHUTDOWN, 4);
    // Reset values, unmapped read, delay programming
    rd(OOC_ADDR_FORCE, {16'h0, OOC_FORCE_RST});
    rd(OOC_ADDR_SLOT, {24'h0, OOC_SLOT_RST});
    rd(OOC_ADDR_UP_DLY, {16'h0, OOC_DLY_RST});
    rd(8'hFC, 32'h0);
    wr(OOC_ADDR_UP_DLY, 32'h0);
    wr(OOC_ADDR_DN_DLY, 32'h0);
    rd(OOC_ADDR_DN_DLY, 32'h0);
    // Bias request and each lockout
    wr(OOC_ADDR_CTRL, 32'h4);
    ws(OOC_ST_STANDBY, 4);
    for (int k = 0; k < 3; k++) begin
      lock <= 3'h1 << k;
      ws(OOC_ST_SHUTDOWN, 3);
      repeat (2) @(posedge sys_clk_i);
      #1;
      `CHK(state_o, OOC_ST_SHUTDOWN)
      lock <= 3'h0;
      ws(OOC_ST_STANDBY, 4);
    end
    // Watchdog and manual reset kill standby
    wdt_expired_i <= 1'b1;
    ws(OOC_ST_SHUTDOWN, 3);
    wdt_expired_i <= 1'b0;
    ws(OOC_ST_STANDBY, 4);
    manual_reset_flag_i <= 1'b1;
    ws(OOC_ST_SHUTDOWN, 3);
    manual_reset_flag_i <= 1'b0;
    ws(OOC_ST_STANDBY, 4);
    wr(OOC_ADDR_CTRL, {29'h0, 1'b1, OOC_REQ_OFF});
    ws(OOC_ST_SHUTDOWN, 3);
    wr(OOC_ADDR_CTRL, 32'h0);
    ws(OOC_ST_SHUTDOWN, 8);
    // Button wake through the sequencer, then software power-off
    press <= 1'b1;
    ws(OOC_ST_STANDBY, 6);
    ws(OOC_ST_PWRUP, 3);
    `CHK(wake_flag_o, 1'b1)
    ws(OOC_ST_ON, 2000);
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK(rail_en_o, 4'hF)
    rd(OOC_ADDR_STATUS, {18'h0, 1'b0, 4'hF, 1'b1, 1'b1, OOC_ST_ON});
    press <= 1'b0;
    wr(OOC_ADDR_CTRL, {30'h0, OOC_REQ_OFF});
    ws(OOC_ST_PWRDN, 3);
    ws(OOC_ST_STANDBY, 2000);
    ws(OOC_ST_SHUTDOWN, 4);
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK(rail_en_o, 4'h0)
    // Force-enable and monitor selector hold resource-on
    wr(OOC_ADDR_FORCE, 32'h0F01);
    ws(OOC_ST_ON, 8);
    `CHK(rail_en_o, 4'h1)
    wr(OOC_ADDR_FORCE, 32'h0F00);
    ws(OOC_ST_STANDBY, 4);
    ws(OOC_ST_SHUTDOWN, 4);
    wr(OOC_ADDR_CTRL, 32'h8);
    ws(OOC_ST_ON, 8);
    rd(OOC_ADDR_CTRL, 32'h8);
    wr(OOC_ADDR_CTRL, 32'h0);
    ws(OOC_ST_SHUTDOWN, 8);
    // Cold reset code wakes, manual reset powers down
    wr(OOC_ADDR_CTRL, {30'h0, OOC_REQ_COLD});
    ws(OOC_ST_ON, 2000);
    manual_reset_flag_i <= 1'b1;
    ws(OOC_ST_PWRDN, 3);
    manual_reset_flag_i <= 1'b0;
    ws(OOC_ST_SHUTDOWN, 2000);
    // Ship entry, charger exit, supply loss and return
    wr(OOC_ADDR_CTRL, {30'h0, OOC_REQ_SHIP});
    ws(OOC_ST_SHIP, 4);
    plug <= 1'b1;
    ws(OOC_ST_SHUTDOWN, 4);
    plug <= 1'b0;
    supply_ok_i <= 1'b0;
    ws(OOC_ST_REMOVED, 4);
    supply_ok_i <= 1'b1;
    ws(OOC_ST_SHUTDOWN, 4);
    print_verdict();
  end
endmodule // on_off_state_controller_tb
